// ===== tcc_pkg.sv
// shared constants, register selects and carrier types of the timer channel
package tcc_pkg;

  // ----------------------------------------------------------------
  // data widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned EXT_CLOCKS = 4;
  localparam int unsigned CAPTURE_PINS = 2;
  localparam int unsigned PIN_COUNT = EXT_CLOCKS + CAPTURE_PINS;
  localparam int unsigned GR_PER_CHANNEL = 2;
  localparam int unsigned CHANNEL_COUNT = 5;
  localparam int unsigned PHASE_CHANNEL = 2;
  localparam int unsigned BUFFER_CH_LO = 3;
  localparam int unsigned BUFFER_CH_HI = 4;

  // ----------------------------------------------------------------
  // reset values and reserved masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] GR_RESET = 16'hFFFF;
  localparam logic [DATA_W-1:0] BR_RESET = 16'hFFFF;
  localparam logic [DATA_W-1:0] COUNTER_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] COUNTER_MAX = 16'hFFFF;
  localparam logic [DATA_W-1:0] COUNTER_ONE = 16'h0001;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h80;
  localparam logic [CTRL_W-1:0] CTRL_RSVD = 8'h80;
  localparam logic [CTRL_W-1:0] PFC_RESET = 8'h88;
  localparam logic [CTRL_W-1:0] PFC_RSVD = 8'h88;
  localparam logic [CTRL_W-1:0] STATUS_RSVD = 8'hF8;
  localparam logic [CTRL_W-1:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CLR_HI = 6;
  localparam int unsigned CLR_LO = 5;
  localparam int unsigned EDGE_HI = 4;
  localparam int unsigned EDGE_LO = 3;
  localparam int unsigned CKSEL_TOP = 2;
  localparam int unsigned CKSEL_LSB = 0;
  localparam int unsigned FUNC_STRIDE = 4;
  localparam int unsigned FUNC_CAPTURE_BIT = 2;
  localparam int unsigned FLAG_A = 0;
  localparam int unsigned FLAG_B = 1;
  localparam int unsigned FLAG_OVF = 2;
  localparam int unsigned BYTE_W = 8;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_BY_A = 2'h1;
  localparam logic [1:0] CLR_BY_B = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  localparam logic [1:0] DIV_8 = 2'h3;
  localparam logic [2:0] PRESCALE_ALL = 3'h7;

  // ----------------------------------------------------------------
  // register selects on the internal bus
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_COUNTER_CONTROL = 3'b000,
    SEL_PIN_FUNCTION = 3'b001,
    SEL_CHANNEL_STATUS = 3'b010,
    SEL_CHANNEL_COUNTER = 3'b011,
    SEL_COMPARE_CAPTURE_A = 3'b100,
    SEL_COMPARE_CAPTURE_B = 3'b101,
    SEL_BUFFER_A = 3'b110,
    SEL_BUFFER_B = 3'b111
  } tcc_reg_sel_e;

  // ----------------------------------------------------------------
  // bus request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    tcc_reg_sel_e sel;
    logic [1:0] be;
    logic [DATA_W-1:0] wdata;
  } tcc_cpu_req_s;

endpackage : tcc_pkg

// ===== tcc_edge_detect.sv
// pin sampler that gives one-cycle rise and fall pulses per pin
`timescale 1ns/1ps
module tcc_edge_detect #(
  parameter int unsigned N = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [N-1:0] pin,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (N < 1)
  begin : g_bad_width
    $error("tcc_edge_detect needs at least one pin");
  end

  // ----------------------------------------------------------------
  // per pin sampling
  // ----------------------------------------------------------------
  logic [N-1:0] last;

  for (genvar i = 0; i < N; i++)
  begin : g_pin
    // previous sample on the system clock
    always_ff @(posedge clock)
    begin
      if (rst)
      begin
        last[i] <= pin[i];
      end
      else
      begin
        last[i] <= pin[i];
      end
    end
    assign rise[i] = pin[i] & ~last[i];
    assign fall[i] = ~pin[i] & last[i];
  end

endmodule : tcc_edge_detect

// ===== tcc_channel.sv
// one compare and capture channel of the timer with counter and registers
//
// Operation
// - two 16-bit general registers per channel
// - output compare sets event flag on equality
// - capture stores counter and sets flag together
// - pwm modes override per-register function selection
// - general registers take word and byte access
// - reset or standby: compare function, all ones
// - buffer registers only in channels three, four
// - compare match copies buffer into general register
// - capture moves old general value into buffer
// - one buffer enable bit per register pair
// - buffers reset to all ones, word/byte access
// - control resets to 80, top bit reads one
// - clear field picks none, a, b, synchronous
// - clear event is match or capture by function
// - edge field picks rising, falling or both
// - clock select: internal divided or external pins
// - internal ticks on divider, external on edges
// - phase counting overrides channel two clock fields
`timescale 1ns/1ps
module tcc_channel #(
  parameter int unsigned CHANNEL = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic standby,
  input wire tcc_pkg::tcc_cpu_req_s cpu_req,
  output logic [tcc_pkg::DATA_W-1:0] rdata,
  output logic rd_valid,
  input wire logic [tcc_pkg::EXT_CLOCKS-1:0] ext_clock,
  input wire logic capture_in_a,
  input wire logic capture_in_b,
  input wire logic pwm_mode,
  input wire logic phase_count_enable,
  input wire logic phase_step,
  input wire logic phase_up,
  input wire logic buffer_enable_a,
  input wire logic buffer_enable_b,
  input wire logic sync_clear_in,
  output logic clear_event,
  output logic event_flag_a,
  output logic event_flag_b,
  output logic overflow_flag
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (CHANNEL >= tcc_pkg::CHANNEL_COUNT)
  begin : g_bad_channel
    $error("tcc_channel index out of range");
  end

  localparam bit HAS_BUFFER = (CHANNEL == tcc_pkg::BUFFER_CH_LO) ||
                              (CHANNEL == tcc_pkg::BUFFER_CH_HI);
  localparam bit HAS_PHASE = (CHANNEL == tcc_pkg::PHASE_CHANNEL);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned GRN = tcc_pkg::GR_PER_CHANNEL;
  logic sys_rst;
  logic [tcc_pkg::CTRL_W-1:0] counter_control;
  logic [tcc_pkg::CTRL_W-1:0] pin_function_control;
  logic [tcc_pkg::DATA_W-1:0] channel_counter;
  logic [tcc_pkg::DATA_W-1:0] next_counter;
  logic [tcc_pkg::DATA_W-1:0] gr [GRN];
  logic [tcc_pkg::DATA_W-1:0] br [GRN];
  logic [GRN-1:0] flag;
  logic [GRN-1:0] buf_en;
  logic [GRN-1:0] buf_on;
  logic [GRN-1:0] is_capture;
  logic [GRN-1:0] is_compare;
  logic [GRN-1:0] cap_edge;
  logic [GRN-1:0] match;
  logic [GRN-1:0] capture;
  logic [GRN-1:0] gr_event;
  logic [GRN-1:0] wr_gr;
  logic [GRN-1:0] wr_br;
  logic [tcc_pkg::PIN_COUNT-1:0] pins;
  logic [tcc_pkg::PIN_COUNT-1:0] pin_rise;
  logic [tcc_pkg::PIN_COUNT-1:0] pin_fall;
  logic [2:0] prescale;
  logic int_tick;
  logic ext_tick;
  logic count_tick;
  logic count_down;
  logic phase_active;
  logic counter_clear;
  logic wrap;
  logic [1:0] clr_sel;
  logic [1:0] edge_sel;
  logic [1:0] src_sel;
  logic ext_mode;
  logic wr_ctrl;
  logic wr_pfc;
  logic wr_status;
  logic wr_counter;

  assign sys_rst = rst | standby;

  // ----------------------------------------------------------------
  // byte lane merge
  // ----------------------------------------------------------------
  function automatic logic [tcc_pkg::DATA_W-1:0] merge(
    input logic [tcc_pkg::DATA_W-1:0] old,
    input logic [tcc_pkg::DATA_W-1:0] wdata,
    input logic [1:0] be
  );
    logic [tcc_pkg::DATA_W-1:0] res;
    res = old;
    if (be[0])
    begin
      res[tcc_pkg::BYTE_W-1:0] = wdata[tcc_pkg::BYTE_W-1:0];
    end
    if (be[1])
    begin
      res[tcc_pkg::DATA_W-1:tcc_pkg::BYTE_W] =
        wdata[tcc_pkg::DATA_W-1:tcc_pkg::BYTE_W];
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_ctrl = cpu_req.wr && cpu_req.be[0] &&
                   (cpu_req.sel == tcc_pkg::SEL_COUNTER_CONTROL);
  assign wr_pfc = cpu_req.wr && cpu_req.be[0] &&
                  (cpu_req.sel == tcc_pkg::SEL_PIN_FUNCTION);
  assign wr_status = cpu_req.wr && cpu_req.be[0] &&
                     (cpu_req.sel == tcc_pkg::SEL_CHANNEL_STATUS);
  assign wr_counter = cpu_req.wr &&
                      (cpu_req.sel == tcc_pkg::SEL_CHANNEL_COUNTER);
  assign wr_gr[0] = cpu_req.wr &&
                    (cpu_req.sel == tcc_pkg::SEL_COMPARE_CAPTURE_A);
  assign wr_gr[1] = cpu_req.wr &&
                    (cpu_req.sel == tcc_pkg::SEL_COMPARE_CAPTURE_B);
  assign wr_br[0] = HAS_BUFFER && cpu_req.wr &&
                    (cpu_req.sel == tcc_pkg::SEL_BUFFER_A);
  assign wr_br[1] = HAS_BUFFER && cpu_req.wr &&
                    (cpu_req.sel == tcc_pkg::SEL_BUFFER_B);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      counter_control <= tcc_pkg::CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      counter_control <= cpu_req.wdata[tcc_pkg::CTRL_W-1:0] |
                         tcc_pkg::CTRL_RSVD;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pin_function_control <= tcc_pkg::PFC_RESET;
    end
    else if (wr_pfc)
    begin
      pin_function_control <= cpu_req.wdata[tcc_pkg::CTRL_W-1:0] |
                              tcc_pkg::PFC_RSVD;
    end
  end

  assign clr_sel = counter_control[tcc_pkg::CLR_HI:tcc_pkg::CLR_LO];
  assign edge_sel = counter_control[tcc_pkg::EDGE_HI:tcc_pkg::EDGE_LO];
  assign ext_mode = counter_control[tcc_pkg::CKSEL_TOP];
  assign src_sel = counter_control[tcc_pkg::CKSEL_LSB +: 2];

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  assign pins = {capture_in_b, capture_in_a, ext_clock};

  tcc_edge_detect #(
    .N(tcc_pkg::PIN_COUNT)
  ) u_edges (
    .clock(clock),
    .rst(sys_rst),
    .pin(pins),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ----------------------------------------------------------------
  // count source
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      prescale <= 3'h0;
    end
    else
    begin
      prescale <= prescale + 3'h1;
    end
  end

  always_comb
  begin
    unique case (src_sel)
      tcc_pkg::DIV_1: int_tick = 1'b1;
      tcc_pkg::DIV_2: int_tick = prescale[0];
      tcc_pkg::DIV_4: int_tick = &prescale[1:0];
      tcc_pkg::DIV_8: int_tick = (prescale == tcc_pkg::PRESCALE_ALL);
    endcase
  end

  always_comb
  begin
    if (edge_sel[1])
    begin
      ext_tick = pin_rise[src_sel] | pin_fall[src_sel];
    end
    else if (edge_sel[0])
    begin
      ext_tick = pin_fall[src_sel];
    end
    else
    begin
      ext_tick = pin_rise[src_sel];
    end
  end

  assign phase_active = HAS_PHASE && phase_count_enable;
  assign count_tick = phase_active ? phase_step :
                      (ext_mode ? ext_tick : int_tick);
  assign count_down = phase_active && !phase_up;

  // ----------------------------------------------------------------
  // per register function, compare and capture
  // ----------------------------------------------------------------
  assign buf_en = {buffer_enable_b, buffer_enable_a};

  for (genvar i = 0; i < GRN; i++)
  begin : g_gr
    logic [2:0] func;
    logic [1:0] cedge;
    localparam int unsigned PIN_IDX = tcc_pkg::EXT_CLOCKS + i;

    assign func = pin_function_control[i*tcc_pkg::FUNC_STRIDE +: 3];
    assign cedge = func[1:0];
    assign is_capture[i] = !pwm_mode &&
                           func[tcc_pkg::FUNC_CAPTURE_BIT];
    assign is_compare[i] = !is_capture[i];
    assign cap_edge[i] = cedge[1] ? (pin_rise[PIN_IDX] | pin_fall[PIN_IDX]) :
                         (cedge[0] ? pin_fall[PIN_IDX] : pin_rise[PIN_IDX]);
    assign match[i] = is_compare[i] && count_tick &&
                      (channel_counter == gr[i]);
    assign capture[i] = is_capture[i] && cap_edge[i];
    assign gr_event[i] = match[i] | capture[i];
    assign buf_on[i] = HAS_BUFFER && buf_en[i];

    // general register
    always_ff @(posedge clock)
    begin
      if (sys_rst)
      begin
        gr[i] <= tcc_pkg::GR_RESET;
      end
      else if (capture[i])
      begin
        gr[i] <= channel_counter;
      end
      else if (match[i] && buf_on[i])
      begin
        gr[i] <= br[i];
      end
      else if (wr_gr[i])
      begin
        gr[i] <= merge(gr[i], cpu_req.wdata, cpu_req.be);
      end
    end

    // buffer register
    always_ff @(posedge clock)
    begin
      if (sys_rst)
      begin
        br[i] <= tcc_pkg::BR_RESET;
      end
      else if (capture[i] && buf_on[i])
      begin
        br[i] <= gr[i];
      end
      else if (wr_br[i])
      begin
        br[i] <= merge(br[i], cpu_req.wdata, cpu_req.be);
      end
    end

    // event flag, set wins over clear
    always_ff @(posedge clock)
    begin
      if (sys_rst)
      begin
        flag[i] <= 1'b0;
      end
      else if (gr_event[i])
      begin
        flag[i] <= 1'b1;
      end
      else if (wr_status && !cpu_req.wdata[i])
      begin
        flag[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter clearing
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (clr_sel)
      tcc_pkg::CLR_NONE: counter_clear = 1'b0;
      tcc_pkg::CLR_BY_A: counter_clear = gr_event[tcc_pkg::FLAG_A];
      tcc_pkg::CLR_BY_B: counter_clear = gr_event[tcc_pkg::FLAG_B];
      tcc_pkg::CLR_SYNC: counter_clear = sync_clear_in;
    endcase
  end

  // ----------------------------------------------------------------
  // channel counter
  // ----------------------------------------------------------------
  always_comb
  begin
    next_counter = channel_counter;
    wrap = 1'b0;
    if (counter_clear)
    begin
      next_counter = tcc_pkg::COUNTER_RESET;
    end
    else if (wr_counter)
    begin
      next_counter = merge(channel_counter, cpu_req.wdata, cpu_req.be);
    end
    else if (count_tick && count_down)
    begin
      next_counter = channel_counter - tcc_pkg::COUNTER_ONE;
      wrap = (channel_counter == tcc_pkg::COUNTER_RESET);
    end
    else if (count_tick)
    begin
      next_counter = channel_counter + tcc_pkg::COUNTER_ONE;
      wrap = (channel_counter == tcc_pkg::COUNTER_MAX);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      channel_counter <= tcc_pkg::COUNTER_RESET;
    end
    else
    begin
      channel_counter <= next_counter;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      overflow_flag <= 1'b0;
    end
    else if (wrap)
    begin
      overflow_flag <= 1'b1;
    end
    else if (wr_status && !cpu_req.wdata[tcc_pkg::FLAG_OVF])
    begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      clear_event <= 1'b0;
    end
    else
    begin
      clear_event <= counter_clear;
    end
  end

  assign event_flag_a = flag[tcc_pkg::FLAG_A];
  assign event_flag_b = flag[tcc_pkg::FLAG_B];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdata <= tcc_pkg::COUNTER_RESET;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= cpu_req.rd;
      if (cpu_req.rd)
      begin
        unique case (cpu_req.sel)
          tcc_pkg::SEL_COUNTER_CONTROL:
            rdata <= {tcc_pkg::BYTE_ZERO, counter_control};
          tcc_pkg::SEL_PIN_FUNCTION:
            rdata <= {tcc_pkg::BYTE_ZERO, pin_function_control};
          tcc_pkg::SEL_CHANNEL_STATUS:
            rdata <= {tcc_pkg::BYTE_ZERO, tcc_pkg::STATUS_RSVD[7:3],
                      overflow_flag, flag};
          tcc_pkg::SEL_CHANNEL_COUNTER:
            rdata <= channel_counter;
          tcc_pkg::SEL_COMPARE_CAPTURE_A:
            rdata <= gr[0];
          tcc_pkg::SEL_COMPARE_CAPTURE_B:
            rdata <= gr[1];
          tcc_pkg::SEL_BUFFER_A:
            rdata <= HAS_BUFFER ? br[0] : tcc_pkg::COUNTER_RESET;
          tcc_pkg::SEL_BUFFER_B:
            rdata <= HAS_BUFFER ? br[1] : tcc_pkg::COUNTER_RESET;
        endcase
      end
    end
  end

endmodule : tcc_channel

// ===== tcc_pin_model.sv
// far-side pin model: capture and external clock pins of one channel
`timescale 1ns/1ps
module tcc_pin_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] toggle,
  input wire logic [5:0] auto_run,
  output logic [3:0] ext_clock,
  output logic capture_in_a,
  output logic capture_in_b
);
  logic [1:0] div;
  logic [5:0] pins;
  // pins move only on clock edges and stand still unless asked
  always_ff @(posedge clock)
  begin
    if (rst)
      div <= 2'h0;
    else
      div <= div + 2'h1;
  end
  always_ff @(posedge clock)
  begin
    if (rst)
      pins <= 6'h00;
    else
      pins <= pins ^ toggle ^ (div == 2'h0 ? auto_run : 6'h00);
  end
  assign ext_clock = pins[3:0];
  assign capture_in_a = pins[4];
  assign capture_in_b = pins[5];
endmodule : tcc_pin_model

// ===== tcc_channel_properties.sv
// concurrent checks on the ports of one timer channel
`timescale 1ns/1ps
module tcc_channel_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic standby,
  input wire tcc_pkg::tcc_cpu_req_s cpu_req,
  input wire logic [tcc_pkg::DATA_W-1:0] rdata,
  input wire logic rd_valid,
  input wire logic sync_clear_in,
  input wire logic clear_event,
  input wire logic event_flag_a,
  input wire logic event_flag_b,
  input wire logic overflow_flag
);
  // ------------------------------------------------------------
  // control shadow and properties
  // ------------------------------------------------------------
  logic [7:0] ctrl;
  logic st_wr;
  logic ctl_wr;
  assign st_wr = cpu_req.wr && cpu_req.be[0]
    && cpu_req.sel == tcc_pkg::SEL_CHANNEL_STATUS;
  assign ctl_wr = cpu_req.wr && cpu_req.be[0]
    && cpu_req.sel == tcc_pkg::SEL_COUNTER_CONTROL;
  always_ff @(posedge clock)
  begin
    if (rst || standby)
      ctrl <= tcc_pkg::CTRL_RESET;
    else if (ctl_wr)
      ctrl <= cpu_req.wdata[7:0] | tcc_pkg::CTRL_RSVD;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst || standby);
  a_reset_quiet: assert property (disable iff (1'b0)
    rst || standby |=> !event_flag_a && !event_flag_b && !overflow_flag
    && !rd_valid && !clear_event)
    else $error("outputs not quiet after reset");
  a_read_valid: assert property (cpu_req.rd |=> rd_valid)
    else $error("read without valid");
  a_valid_cause: assert property (!cpu_req.rd |=> !rd_valid)
    else $error("valid without read");
  a_flag_a_holds: assert property (event_flag_a
    && !(st_wr && !cpu_req.wdata[0]) |=> event_flag_a)
    else $error("flag a dropped without clear");
  a_flag_b_holds: assert property (event_flag_b
    && !(st_wr && !cpu_req.wdata[1]) |=> event_flag_b)
    else $error("flag b dropped without clear");
  a_sync_clear: assert property (sync_clear_in
    && ctrl[6:5] == tcc_pkg::CLR_SYNC |=> clear_event)
    else $error("no clear event after sync clear");
  a_ctrl_readback: assert property (cpu_req.rd
    && cpu_req.sel == tcc_pkg::SEL_COUNTER_CONTROL
    |=> rdata == {8'h00, $past(ctrl)})
    else $error("control readback wrong");
  a_status_readback: assert property (cpu_req.rd
    && cpu_req.sel == tcc_pkg::SEL_CHANNEL_STATUS |=> rdata == {8'h00, 5'h1F,
    $past(overflow_flag), $past(event_flag_b), $past(event_flag_a)})
    else $error("status readback wrong");
endmodule : tcc_channel_properties
bind tcc_channel tcc_channel_properties props (.clock(clock), .rst(rst),
  .standby(standby), .cpu_req(cpu_req), .rdata(rdata), .rd_valid(rd_valid),
  .sync_clear_in(sync_clear_in), .clear_event(clear_event),
  .event_flag_a(event_flag_a), .event_flag_b(event_flag_b),
  .overflow_flag(overflow_flag));

// ===== test_timer_channel_compare_capture.sv
// self-checking bench of timer channel three, with channel two for phase counting, against a bench model
`timescale 1ns/1ps
module test_timer_channel_compare_capture;
  // ------------------------------------------------------------
  // bench signals, model and tasks
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  tcc_pkg::tcc_cpu_req_s cpu_req = '0;
  logic [15:0] rdata;
  logic rd_valid, clear_event, event_flag_a, event_flag_b, overflow_flag;
  logic [3:0] ext_clock;
  logic capture_in_a, capture_in_b;
  logic pwm_mode = 1'b0;
  logic buf_a = 1'b0;
  logic buf_b = 1'b0;
  logic sync_clear_in = 1'b0;
  logic ph_en = 1'b0;
  logic ph_step = 1'b0;
  logic ovf2;
  logic [5:0] toggle = 6'h00;
  logic [5:0] auto_run = 6'h00;
  logic [15:0] v, w, x;
  int n_fail = 0;
  int n_checks = 0;
  int mdl [8];
  int c, n, s;
  int sels [6] = '{0, 1, 4, 5, 6, 7};

  always #10 clock = ~clock;

  tcc_channel #(.CHANNEL(3)) dut (.clock(clock), .rst(rst),
    .standby(standby), .cpu_req(cpu_req), .rdata(rdata),
    .rd_valid(rd_valid), .ext_clock(ext_clock),
    .capture_in_a(capture_in_a), .capture_in_b(capture_in_b),
    .pwm_mode(pwm_mode), .phase_count_enable(1'b0), .phase_step(1'b0),
    .phase_up(1'b0), .buffer_enable_a(buf_a), .buffer_enable_b(buf_b),
    .sync_clear_in(sync_clear_in), .clear_event(clear_event),
    .event_flag_a(event_flag_a), .event_flag_b(event_flag_b),
    .overflow_flag(overflow_flag));

  tcc_pin_model pins (.clock(clock), .rst(rst), .toggle(toggle),
    .auto_run(auto_run), .ext_clock(ext_clock),
    .capture_in_a(capture_in_a), .capture_in_b(capture_in_b));

  tcc_channel #(.CHANNEL(2)) dut_phase (.clock(clock), .rst(rst),
    .standby(standby), .cpu_req(cpu_req), .rdata(), .rd_valid(),
    .ext_clock(ext_clock), .capture_in_a(capture_in_a),
    .capture_in_b(capture_in_b), .pwm_mode(pwm_mode),
    .phase_count_enable(ph_en), .phase_step(ph_step), .phase_up(1'b0),
    .buffer_enable_a(buf_a), .buffer_enable_b(buf_b),
    .sync_clear_in(sync_clear_in), .clear_event(), .event_flag_a(),
    .event_flag_b(), .overflow_flag(ovf2));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic bus(input logic r, input logic wr, input int sl,
    input logic [1:0] be, input logic [15:0] d);
    @(negedge clock);
    cpu_req = {r, wr, 3'(sl), be, d};
    @(negedge clock);
    cpu_req = '0;
    if (wr && be[0])
      mdl[sl][7:0] = d[7:0] | (sl == 0 ? 8'h80 : sl == 1 ? 8'h88 : 8'h00);
    if (wr && be[1] && sl > 3)
      mdl[sl][15:8] = d[15:8];
    if (r)
    begin
      chk({15'h0000, rd_valid}, 16'h0001);
      v = rdata;
    end
  endtask : bus

  task automatic wr(input int sl, input logic [1:0] be, input logic [15:0] d);
    bus(1'b0, 1'b1, sl, be, d);
  endtask : wr

  task automatic rd(input int sl);
    bus(1'b1, 1'b0, sl, 2'h3, 16'h0000);
  endtask : rd

  task automatic rd_all;
    mdl = '{'h80, 'h88, 'hF8, 0, 'hFFFF, 'hFFFF, 'hFFFF, 'hFFFF};
    for (int i = 0; i < 8; i++)
    begin
      if (i == 3)
        continue;
      rd(i);
      chk(v, 16'(mdl[i]));
    end
  endtask : rd_all

  task automatic pulse_pin(input int b);
    @(negedge clock);
    toggle[b] = 1'b1;
    @(negedge clock);
    toggle = 6'h00;
  endtask : pulse_pin

  task automatic gap(output int cnt);
    cnt = 0;
    while (clear_event !== 1'b1 && cnt < 3000)
    begin
      @(negedge clock);
      cnt++;
    end
    @(negedge clock);
    cnt = 1;
    while (clear_event !== 1'b1 && cnt < 3000)
    begin
      @(negedge clock);
      cnt++;
    end
  endtask : gap

  task automatic period(input int e);
    gap(c);
    gap(c);
    chk(16'(c), 16'(e));
  endtask : period

  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'h456B1016));
    repeat (20) @(negedge clock);
    rst = 1'b0;
    rd_all();
    for (int i = 0; i < 24; i++)
    begin
      s = sels[$urandom_range(5)];
      wr(s, 2'($urandom_range(3, 1)), 16'($urandom));
      rd(s);
      chk(v, 16'(mdl[s]));
    end
    wr(1, 2'h1, 16'h0000);
    for (int d = 0; d < 4; d++)
    begin
      n = 8 + $urandom_range(15);
      wr(4, 2'h3, 16'(n));
      wr(0, 2'h1, 16'(32'h20 | d));
      wr(3, 2'h3, 16'h0000);
      period((n + 1) << d);
    end
    wr(4, 2'h3, 16'h0003);
    for (int i = 0; i < 16; i++)
    begin
      auto_run = 6'h00;
      wr(0, 2'h1, 16'(32'h24 | (i & 3) | ((i >> 2) << 3)));
      wr(3, 2'h3, 16'h0000);
      auto_run = 6'(1 << (i & 3));
      period(i > 7 ? 16 : 32);
    end
    auto_run = 6'h00;
    buf_a = 1'b1;
    wr(0, 2'h1, 16'h0000);
    for (int cd = 4; cd < 8; cd++)
    begin
      wr(1, 2'h1, 16'(cd));
      wr(2, 2'h1, 16'h0000);
      repeat (4)
      begin
        pulse_pin(4);
        repeat (4) @(negedge clock);
      end
      rd(4);
      w = v;
      rd(6);
      chk(w - v, cd > 5 ? 16'h0006 : 16'h000C);
      chk({15'h0000, event_flag_a}, 16'h0001);
    end
    ph_en = 1'b1;
    wr(2, 2'h1, 16'h0000);
    wr(3, 2'h3, 16'hFFFE);
    repeat (3) @(negedge clock);
    chk({15'h0000, overflow_flag}, 16'h0001);
    chk({15'h0000, ovf2}, 16'h0000);
    wr(3, 2'h3, 16'h0000);
    ph_step = 1'b1;
    @(negedge clock);
    ph_step = 1'b0;
    chk({15'h0000, ovf2}, 16'h0001);
    ph_en = 1'b0;
    wr(1, 2'h1, 16'h0000);
    x = 16'(100 + $urandom_range(999));
    wr(6, 2'h3, x);
    wr(7, 2'h3, 16'h0055);
    wr(5, 2'h3, 16'h000C);
    wr(4, 2'h3, 16'h000A);
    wr(0, 2'h1, 16'h0020);
    wr(3, 2'h3, 16'h0000);
    wr(2, 2'h1, 16'h0000);
    repeat (40) @(negedge clock);
    rd(4);
    chk(v, x);
    rd(5);
    chk(v, 16'h000C);
    chk({15'h0000, event_flag_b}, 16'h0001);
    buf_a = 1'b0;
    wr(1, 2'h1, 16'h0004);
    wr(4, 2'h3, 16'h1234);
    pwm_mode = 1'b1;
    pulse_pin(4);
    pulse_pin(4);
    rd(4);
    chk(v, 16'h1234);
    pwm_mode = 1'b0;
    wr(0, 2'h1, 16'h0060);
    @(negedge clock);
    sync_clear_in = 1'b1;
    @(negedge clock);
    chk({15'h0000, clear_event}, 16'h0001);
    sync_clear_in = 1'b0;
    @(negedge clock);
    standby = 1'b1;
    @(negedge clock);
    standby = 1'b0;
    rd_all();
    print_verdict();
  end
endmodule : test_timer_channel_compare_capture
